// *** logic/fll_clock_map.svh ***
// Register offsets, field positions, reset values and timing counts of the clock unit
`ifndef FLL_CLOCK_MAP_SVH
`define FLL_CLOCK_MAP_SVH

// Byte addresses inside the 16-byte register window
`define ADDR_CTRL_ONE     4'h0
`define ADDR_CTRL_TWO     4'h4
`define ADDR_TRIM         4'h8
`define ADDR_STATUS       4'hC

// First control register fields
`define SRC_SEL_HI        7
`define SRC_SEL_LO        6
`define REF_DIV_HI        5
`define REF_DIV_LO        3
`define REF_SEL_BIT       2
`define INT_OUT_EN_BIT    1
`define INT_KEEP_BIT      0

// Second control register fields
`define BUS_DIV_HI        7
`define BUS_DIV_LO        6
`define OSC_RANGE_BIT     5
`define OSC_GAIN_BIT      4
`define LOOP_LOWPWR_BIT   3
`define EXT_OSC_BIT       2
`define EXT_OUT_EN_BIT    1
`define EXT_KEEP_BIT      0

// Status register fields
`define FINE_BIT          0
`define ACT_SRC_HI        3
`define ACT_SRC_LO        2
`define MODE_HI           6
`define MODE_LO           4

// Source select encodings
`define SRC_LOOP          2'h0
`define SRC_INT           2'h1
`define SRC_EXT           2'h2
`define SRC_RSVD          2'h3

// Reset values
`define CTRL_ONE_RST      8'h04
`define CTRL_TWO_RST      8'h40
`define TRIM_RST          8'h80
`define FINE_RST          1'b0

// Timing
`define CLK_PERIOD_NS     5
`define SWITCH_EDGES      3'h4
`define SWITCH_TIMEOUT_NS 100000
`define SWITCH_TIMEOUT_CYC (`SWITCH_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

// *** logic/fll_clock_pkg.sv ***
// Types shared by the clock unit
`default_nettype none
package fll_clock_pkg;

  // Clock modes, derived from the active source and control bits
  typedef enum logic [2:0] {
    LOOP_ENGAGED_INTERNAL,
    LOOP_ENGAGED_EXTERNAL,
    LOOP_BYPASSED_INTERNAL,
    BYPASSED_INTERNAL_LOWPOWER,
    LOOP_BYPASSED_EXTERNAL,
    BYPASSED_EXTERNAL_LOWPOWER
  } mode_t;

endpackage : fll_clock_pkg
`default_nettype wire

// *** logic/pin_sync.sv ***
// Two-flop synchronisers with rising-edge ticks for clock pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int N = 3
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         clkEn,
  // Pins
  input  wire logic [N-1:0] pinIn,
  // Synced level and edge pulse
  output logic      [N-1:0] level,
  output logic      [N-1:0] rise
);

  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [N-1:0] prev;
    logic [N-1:0] rise;
  } sync_t;

  sync_t st;
  sync_t next_st;

  // Edge detect looks only at the second and third flops, never the first
  always_comb begin
    next_st      = st;
    next_st.meta = pinIn;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
    next_st.rise = st.sync & ~st.prev;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign level = st.prev;
  assign rise  = st.rise;

endmodule : pin_sync
`default_nettype wire

// *** logic/tick_divider.sv ***
// Divides a tick stream by two to the power of a select value
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int SELW = 3
) (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            nrst,
  input  wire logic            clkEn,
  // Tick in, ratio and tick out
  input  wire logic            tickIn,
  input  wire logic [SELW-1:0] sel,
  output logic                 tickOut
);

  localparam int CNTW = (2 ** SELW) - 1;

  typedef struct packed {
    logic [CNTW-1:0] cnt;
    logic            tickOut;
  } div_t;

  div_t            st;
  div_t            next_st;
  logic [CNTW-1:0] mask;

  // Ratio change acts at once: the mask alone decides the next pulse
  always_comb begin
    next_st         = st;
    mask            = CNTW'((CNTW'(1) << sel) - CNTW'(1));
    next_st.tickOut = tickIn && ((st.cnt & mask) == mask);
    if (tickIn) begin
      next_st.cnt = st.cnt + CNTW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign tickOut = st.tickOut;

endmodule : tick_divider
`default_nettype wire

// *** logic/fll_clock_regs.sv ***
// Clock source control and trim registers with AHB-Lite access
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fll_clock_map.svh"

// How it works
// [R1] Source field routes loop, internal, external
// [R2] Reference divider divides by two-power value
// [R3] Software keeps divided reference in range
// [R4] Reference select bit picks internal reference
// [R5] Internal output enable gates internal clock
// [R6] Internal reference kept in stop conditionally
// [R7] Bus divider divides by 1,2,4,8
// [R8] Bus rate is source over divider
// [R9] Range bit sets oscillator band
// [R10] Gain bit sets oscillator high gain
// [R11] Low-power bit stops bypassed loop
// [R12] Source bit requests crystal oscillator
// [R13] External output enable gates external clock
// [R14] External reference kept in stop conditionally
// [R15] Eight-bit trim sets reference period
// [R16] Fine bit extends trim below LSB
// [R17] Fine bit lengthens period by one step
// [R18] Reset starts loop engaged internal
// [R19] Source switch waits edges, else keeps
// [R20] Bus divider change acts at once
// [R21] Fields read back as written
module fll_clock_regs
  import fll_clock_pkg::*;
#(
  parameter int SWITCH_TIMEOUT = `SWITCH_TIMEOUT_CYC
) (
  // Clock, reset and enable
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        clkEn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Clock pins and system state
  input  wire logic        loopClkIn,
  input  wire logic        intRefClkIn,
  input  wire logic        extRefClkIn,
  input  wire logic        stopReq,
  input  wire logic        background_debug_active,
  // Derived clock ticks
  output logic             busClkTick,
  output logic             loopRefTick,
  // Reference clock outputs and run controls
  output logic             int_ref_clock_out,
  output logic             ext_ref_clock_out,
  output logic             intRefRun,
  output logic             extRefRun,
  output logic             loopEnable,
  // Oscillator and trim controls
  output logic             oscHighRange,
  output logic             osc_high_gain,
  output logic             ext_src_osc_select,
  output logic      [8:0]  periodTrim
);

  localparam int TOW = 16;

  typedef struct packed {
    logic [7:0]     ctrlOne;
    logic [7:0]     ctrlTwo;
    logic [7:0]     trim;
    logic           fine;
    logic           wrPend;
    logic [3:0]     wrAddr;
    logic [31:0]    rdData;
    logic [1:0]     activeSrc;
    logic [1:0]     pendSrc;
    logic [2:0]     edgeCnt;
    logic [TOW-1:0] waitCnt;
    logic           stopped;
    logic           intAtStop;
    logic           extAtStop;
    logic           intRun;
    logic           extRun;
    logic           intOut;
    logic           extOut;
    logic           loopEn;
  } state_t;

  state_t      st;
  state_t      next_st;
  mode_t       mode;
  logic [2:0]  pinLevel;
  logic [2:0]  pinRise;
  logic        loopTick;
  logic        intTick;
  logic        extTick;
  logic        srcTick;
  logic        refTick;
  logic        selTick;
  logic [1:0]  wantSrc;
  logic        lowPower;
  logic        modeInt;
  logic        modeExt;
  logic        take;
  logic        mapped;

  // Clock pins are asynchronous to sys_clk
  pin_sync #(.N(3)) u_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .clkEn   (clkEn),
    .pinIn   ({extRefClkIn, intRefClkIn, loopClkIn}),
    .level   (pinLevel),
    .rise    (pinRise)
  );

  assign loopTick = pinRise[0];
  assign intTick  = pinRise[1];
  assign extTick  = pinRise[2];

  // [R4] loop reference choice
  assign refTick = st.ctrlOne[`REF_SEL_BIT] ? intTick : extTick;

  // [R2] reference predivider
  tick_divider #(.SELW(3)) u_refdiv (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .clkEn   (clkEn),
    .tickIn  (refTick),
    .sel     (st.ctrlOne[`REF_DIV_HI:`REF_DIV_LO]),
    .tickOut (loopRefTick)
  );

  // [R1] active source mux
  always_comb begin
    unique case (st.activeSrc)
      `SRC_INT: srcTick = intTick;
      `SRC_EXT: srcTick = extTick;
      default:  srcTick = loopTick;
    endcase
  end

  // [R7] bus divider in series after the source mux
  // [R8] rate is source divided by setting
  // [R20] divider field drives the ratio directly
  tick_divider #(.SELW(2)) u_busdiv (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .clkEn   (clkEn),
    .tickIn  (srcTick),
    .sel     (st.ctrlTwo[`BUS_DIV_HI:`BUS_DIV_LO]),
    .tickOut (busClkTick)
  );

  // [R1] reserved encoding falls back to loop output
  assign wantSrc = (st.ctrlOne[`SRC_SEL_HI:`SRC_SEL_LO] == `SRC_RSVD) ? `SRC_LOOP
                 : st.ctrlOne[`SRC_SEL_HI:`SRC_SEL_LO];

  // Tick of the source being switched to
  always_comb begin
    unique case (st.pendSrc)
      `SRC_INT: selTick = intTick;
      `SRC_EXT: selTick = extTick;
      default:  selTick = loopTick;
    endcase
  end

  // [R11] low power only counts without background debug
  assign lowPower = st.ctrlTwo[`LOOP_LOWPWR_BIT] && !background_debug_active;

  // Mode from the source actually in use
  always_comb begin
    unique case (st.activeSrc)
      `SRC_INT: mode = lowPower ? BYPASSED_INTERNAL_LOWPOWER : LOOP_BYPASSED_INTERNAL;
      `SRC_EXT: mode = lowPower ? BYPASSED_EXTERNAL_LOWPOWER : LOOP_BYPASSED_EXTERNAL;
      default:  mode = st.ctrlOne[`REF_SEL_BIT] ? LOOP_ENGAGED_INTERNAL
                                                : LOOP_ENGAGED_EXTERNAL;
    endcase
  end

  assign modeInt = (mode == LOOP_ENGAGED_INTERNAL) || (mode == LOOP_BYPASSED_INTERNAL)
                || (mode == BYPASSED_INTERNAL_LOWPOWER);
  assign modeExt = !modeInt;

  // Bus decode: word transfers inside the window only
  assign take   = hsel && hready && htrans[1];
  assign mapped = (haddr[31:4] == 28'h0000000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);

  always_comb begin
    next_st = st;

    // [R21] data phase write stores fields as written
    if (st.wrPend) begin
      unique case (st.wrAddr)
        `ADDR_CTRL_ONE: next_st.ctrlOne = hwdata[7:0];
        `ADDR_CTRL_TWO: next_st.ctrlTwo = hwdata[7:0];
        `ADDR_TRIM:     next_st.trim    = hwdata[7:0];
        `ADDR_STATUS:   next_st.fine    = hwdata[`FINE_BIT];
        default:        next_st.fine    = st.fine;
      endcase
    end

    // Address phase; read data built from post-write values for back-to-back access
    if (hready) begin
      next_st.wrPend = take && hwrite && mapped;
      next_st.wrAddr = haddr[3:0];
      next_st.rdData = 32'h00000000;
      if (take && !hwrite && mapped) begin
        unique case (haddr[3:0])
          `ADDR_CTRL_ONE: next_st.rdData = {24'h000000, next_st.ctrlOne};
          `ADDR_CTRL_TWO: next_st.rdData = {24'h000000, next_st.ctrlTwo};
          `ADDR_TRIM:     next_st.rdData = {24'h000000, next_st.trim};
          `ADDR_STATUS: begin
            next_st.rdData[`FINE_BIT]              = next_st.fine;
            next_st.rdData[`ACT_SRC_HI:`ACT_SRC_LO] = st.activeSrc;
            next_st.rdData[`MODE_HI:`MODE_LO]       = 3'(mode);
          end
          default:        next_st.rdData = 32'h00000000;
        endcase
      end
    end

    // [R19] switch after a few edges of the new clock, else keep old
    if (wantSrc != st.activeSrc) begin
      if (wantSrc != st.pendSrc) begin
        next_st.pendSrc = wantSrc;
        next_st.edgeCnt = 3'h0;
        next_st.waitCnt = '0;
      end else if (selTick && (st.edgeCnt == `SWITCH_EDGES - 3'h1)) begin
        next_st.activeSrc = st.pendSrc;
        next_st.edgeCnt   = 3'h0;
        next_st.waitCnt   = '0;
      end else if (st.waitCnt == TOW'(SWITCH_TIMEOUT - 1)) begin
        // Clock absent: old source stays, counting starts over
        next_st.edgeCnt = 3'h0;
        next_st.waitCnt = '0;
      end else begin
        next_st.edgeCnt = st.edgeCnt + 3'(selTick);
        next_st.waitCnt = st.waitCnt + TOW'(1);
      end
    end else begin
      next_st.pendSrc = st.activeSrc;
      next_st.edgeCnt = 3'h0;
      next_st.waitCnt = '0;
    end

    // Mode is remembered on the way into stop
    next_st.stopped = stopReq;
    if (stopReq && !st.stopped) begin
      next_st.intAtStop = modeInt;
      next_st.extAtStop = modeExt;
    end

    // [R6] internal reference run control
    if (st.stopped) begin
      next_st.intRun = st.ctrlOne[`INT_KEEP_BIT]
                    && (st.ctrlOne[`INT_OUT_EN_BIT] || st.intAtStop);
    end else begin
      next_st.intRun = st.ctrlOne[`INT_OUT_EN_BIT] || modeInt;
    end

    // [R14] external reference run control
    if (st.stopped) begin
      next_st.extRun = st.ctrlTwo[`EXT_KEEP_BIT]
                    && (st.ctrlTwo[`EXT_OUT_EN_BIT] || st.extAtStop);
    end else begin
      next_st.extRun = st.ctrlTwo[`EXT_OUT_EN_BIT] || modeExt;
    end

    // [R5] internal clock output gated by its enable
    next_st.intOut = pinLevel[1] && st.ctrlOne[`INT_OUT_EN_BIT] && st.intRun;
    // [R13] external clock output gated by its enable
    next_st.extOut = pinLevel[2] && st.ctrlTwo[`EXT_OUT_EN_BIT] && st.extRun;

    // [R11] loop off in stop and in low-power bypass
    next_st.loopEn = !st.stopped
                  && !(lowPower && (st.activeSrc != `SRC_LOOP));
  end

  // [R18] reset into loop engaged internal, loop output selected
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st         <= '0;
      st.ctrlOne <= `CTRL_ONE_RST;
      st.ctrlTwo <= `CTRL_TWO_RST;
      st.trim    <= `TRIM_RST;
      st.fine    <= `FINE_RST;
      st.intRun  <= 1'b1;
      st.loopEn  <= 1'b1;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st.rdData;

  assign int_ref_clock_out = st.intOut;
  assign ext_ref_clock_out = st.extOut;
  assign intRefRun         = st.intRun;
  assign extRefRun         = st.extRun;
  assign loopEnable        = st.loopEn;

  // [R9] oscillator band
  assign oscHighRange       = st.ctrlTwo[`OSC_RANGE_BIT];
  // [R10] oscillator gain
  assign osc_high_gain      = st.ctrlTwo[`OSC_GAIN_BIT];
  // [R12] crystal or plain clock request
  assign ext_src_osc_select = st.ctrlTwo[`EXT_OSC_BIT];

  // [R15] binary weighted trim, larger is longer
  // [R16] fine bit sits below the trim LSB
  // [R17] fine set adds one smallest step
  assign periodTrim = {st.trim, st.fine};

endmodule : fll_clock_regs
`default_nettype wire

// *** dv/fll_clock_regs_assertions.sv ***
// Port-level assertion checker for the clock unit registers
`timescale 1ns/1ps
`default_nettype none
`include "fll_clock_map.svh"
module fll_clock_regs_checker (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        clkEn,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // System state and controls
  input wire logic        stopReq,
  input wire logic        background_debug_active,
  input wire logic        loopEnable,
  input wire logic        oscHighRange,
  input wire logic        osc_high_gain,
  input wire logic        ext_src_osc_select,
  input wire logic [8:0]  periodTrim
);
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] adr;
  } phase_t;
  phase_t ph;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Data-phase tracker, word accesses only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ph <= '0;
    end else if (hready && clkEn) begin
      ph <= '{hsel && htrans[1] && hsize == 3'h2 && hwrite,
              hsel && htrans[1] && hsize == 3'h2 && !hwrite, haddr};
    end
  end

  // Address match of the current data phase
  function automatic logic at(input logic [3:0] a);
    return ph.adr == 32'(a);
  endfunction

  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus stalled or errored");
  property p_range; ph.wr && at(`ADDR_CTRL_TWO) |=> oscHighRange == $past(hwdata[5]); endproperty
  a_range: assert property (p_range) else $error("band bit not applied");
  property p_gain; ph.wr && at(`ADDR_CTRL_TWO) |=> osc_high_gain == $past(hwdata[4]); endproperty
  a_gain: assert property (p_gain) else $error("gain bit not applied");
  property p_osc; ph.wr && at(`ADDR_CTRL_TWO) |=> ext_src_osc_select == $past(hwdata[2]); endproperty
  a_osc: assert property (p_osc) else $error("oscillator request not applied");
  property p_trim; ph.wr && at(`ADDR_TRIM) |=> periodTrim[8:1] == $past(hwdata[7:0]); endproperty
  a_trim: assert property (p_trim) else $error("trim not applied");
  property p_fine; ph.wr && at(`ADDR_STATUS) |=> periodTrim[0] == $past(hwdata[0]); endproperty
  a_fine: assert property (p_fine) else $error("fine trim not applied");
  property p_rtwo;
    ph.rd && at(`ADDR_CTRL_TWO) |-> hrdata[5:4] == {oscHighRange, osc_high_gain}
      && hrdata[2] == ext_src_osc_select;
  endproperty
  a_rtwo: assert property (p_rtwo) else $error("control two read mismatch");
  property p_rtrim; ph.rd && at(`ADDR_TRIM) |-> hrdata[7:0] == periodTrim[8:1]; endproperty
  a_rtrim: assert property (p_rtrim) else $error("trim read mismatch");
  property p_lowpwr; (background_debug_active && !stopReq && clkEn) [*4] |-> loopEnable; endproperty
  a_lowpwr: assert property (p_lowpwr) else $error("loop off while debug active");
endmodule : fll_clock_regs_checker

bind fll_clock_regs fll_clock_regs_checker u_chk (.sys_clk, .nrst, .clkEn, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .stopReq,
  .background_debug_active, .loopEnable, .oscHighRange, .osc_high_gain,
  .ext_src_osc_select, .periodTrim);
`default_nettype wire

// *** dv/clock_pins_model.sv ***
// Behavioural loop and reference oscillators feeding the clock pins
`timescale 1ns/1ps
`default_nettype none
module clock_pins_model #(
  parameter int LOOP_HALF = 10,
  parameter int INT_HALF  = 15,
  parameter int EXT_HALF  = 25
) (
  // Run controls from the unit
  input wire logic       loopEnable,
  input wire logic       intRefRun,
  input wire logic       extRefRun,
  // Source presence, cleared to model a dead clock
  input wire logic [2:0] alive,
  // Clock pins, low while halted
  output logic           loopClkIn,
  output logic           intRefClkIn,
  output logic           extRefClkIn
);
  // Pins start unknown; the !== test lets a running clock leave X on its first toggle
  // loop halts when disabled
  always #(LOOP_HALF) loopClkIn = loopEnable && alive[0] && (loopClkIn !== 1'b1);
  always #(INT_HALF) intRefClkIn = intRefRun && alive[1] && (intRefClkIn !== 1'b1);
  always #(EXT_HALF) extRefClkIn = extRefRun && alive[2] && (extRefClkIn !== 1'b1);
endmodule : clock_pins_model
`default_nettype wire

// *** dv/tb_fll_clock_regs.sv ***
// Self-checking bench for the clock unit registers
`timescale 1ns/1ps
`default_nettype none
`include "fll_clock_map.svh"
module tb_fll_clock_regs;
  logic        sys_clk, nrst, clkEn, hsel, hwrite, hready, hreadyout, hresp, stopReq, bda;
  logic [1:0]  htrans;
  logic [2:0]  hsize, alive;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic        loopClkIn, intRefClkIn, extRefClkIn, busClkTick, loopRefTick, intOut, extOut;
  logic        intRefRun, extRefRun, loopEnable, oscHighRange, osc_high_gain, ext_src_osc_select;
  logic [8:0]  periodTrim;
  logic [31:0] pat[2] = '{32'h34, 32'hC8};
  int          miscompares, check_count, cyc;
  int          nEdge[3], nTick[2], nOut[2];

  assign hready = hreadyout;
  fll_clock_regs #(.SWITCH_TIMEOUT(64)) dut (.sys_clk, .nrst, .clkEn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .loopClkIn, .intRefClkIn,
    .extRefClkIn, .stopReq, .background_debug_active(bda), .busClkTick, .loopRefTick,
    .int_ref_clock_out(intOut), .ext_ref_clock_out(extOut), .intRefRun, .extRefRun,
    .loopEnable, .oscHighRange, .osc_high_gain, .ext_src_osc_select, .periodTrim);
  clock_pins_model pins (.loopEnable, .intRefRun, .extRefRun, .alive, .loopClkIn,
    .intRefClkIn, .extRefClkIn);

  // Clock, tallies and hang guard
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge loopClkIn) nEdge[0]++;
  always @(posedge intRefClkIn) nEdge[1]++;
  always @(posedge extRefClkIn) nEdge[2]++;
  always @(posedge intOut) nOut[0]++;
  always @(posedge extOut) nOut[1]++;
  always @(posedge sys_clk) begin
    nTick[0] += int'(busClkTick);
    nTick[1] += int'(loopRefTick);
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // Single word transfer; address phase held until ready, then data phase
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Counts may differ by one at window edges
  task automatic near(input int got, input int exp);
    check_count++;
    if (got < exp - 1 || got > exp + 1) begin
      miscompares++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : near

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask : rdc

  task automatic meas(input int p, input int t, input int k);
    int e0;
    int t0;
    e0 = nEdge[p];
    t0 = nTick[t];
    repeat (2000) @(posedge sys_clk);
    near(nTick[t] - t0, (nEdge[p] - e0) >> k);
  endtask : meas

  // Poll the active source field with a bounded count
  task automatic src(input logic [1:0] s);
    xfer(1'b0, `ADDR_STATUS, 32'h0);
    for (int i = 0; i < 40 && rdv[3:2] !== s; i++) xfer(1'b0, `ADDR_STATUS, 32'h0);
    chk(32'(rdv[3:2]), 32'(s));
  endtask : src

  task automatic outs(input int i, input logic [31:0] a, input logic [31:0] v, input int exp);
    int n0;
    wr(a, v);
    repeat (10) @(posedge sys_clk);
    n0 = nOut[i];
    repeat (200) @(posedge sys_clk);
    near(nOut[i] - n0, exp);
  endtask : outs

  task automatic run_chk(input logic stop, input logic dbg, input logic [2:0] exp);
    stopReq <= stop;
    bda <= dbg;
    repeat (10) @(posedge sys_clk);
    chk(32'({intRefRun, extRefRun, loopEnable}), 32'(exp));
  endtask : run_chk

  // Main sequence
  initial begin
    {sys_clk, nrst, hsel, hwrite, stopReq, bda, haddr, hwdata, htrans} = '0;
    clkEn = 1'b1;
    hsize = 3'h2;
    alive = 3'h7;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rdc(`ADDR_CTRL_ONE, 32'h04);
    rdc(`ADDR_CTRL_TWO, 32'h40);
    rdc(`ADDR_TRIM, 32'(`TRIM_RST));
    chk(32'({intRefRun, extRefRun, loopEnable}), 32'h5);
    wr(32'h10, 32'hFF);
    rdc(32'h10, 32'h0);
    rdc(`ADDR_CTRL_ONE, 32'h04);
    $display("test reset and unmapped done");
    foreach (pat[i]) begin
      wr(`ADDR_CTRL_TWO, pat[i]);
      rdc(`ADDR_CTRL_TWO, pat[i]);
      chk(32'({oscHighRange, osc_high_gain, ext_src_osc_select}),
          32'({pat[i][5:4], pat[i][2]}));
    end
    wr(`ADDR_TRIM, 32'h3C);
    wr(`ADDR_STATUS, 32'h1);
    // The write lands on the edge the task returns at; look once it has settled
    @(negedge sys_clk);
    chk(32'(periodTrim), 32'h79);
    rdc(`ADDR_TRIM, 32'h3C);
    wr(`ADDR_STATUS, 32'h0);
    @(negedge sys_clk);
    chk(32'(periodTrim), 32'h78);
    $display("test oscillator and trim done");
    for (int k = 0; k < 8; k++) begin
      wr(`ADDR_CTRL_ONE, 32'(k << 3) | 32'h04);
      meas(1, 1, k);
    end
    wr(`ADDR_CTRL_ONE, 32'h00);
    repeat (20) @(posedge sys_clk);
    meas(2, 1, 0);
    wr(`ADDR_CTRL_ONE, 32'h04);
    for (int b = 0; b < 4; b++) begin
      wr(`ADDR_CTRL_TWO, 32'(b << 6));
      meas(0, 0, b);
    end
    $display("test dividers done");
    wr(`ADDR_CTRL_ONE, 32'h44);
    src(2'h1);
    wr(`ADDR_CTRL_TWO, 32'h80);
    meas(1, 0, 2);
    wr(`ADDR_CTRL_TWO, 32'h02);
    wr(`ADDR_CTRL_ONE, 32'h80);
    src(2'h2);
    meas(2, 0, 0);
    wr(`ADDR_CTRL_ONE, 32'hC4);
    src(2'h0);
    alive <= 3'h3;
    wr(`ADDR_CTRL_ONE, 32'h80);
    repeat (300) @(posedge sys_clk);
    src(2'h0);
    wr(`ADDR_CTRL_ONE, 32'h04);
    alive <= 3'h7;
    $display("test source switch done");
    outs(0, `ADDR_CTRL_ONE, 32'h06, 200 * 5 / 30);
    outs(0, `ADDR_CTRL_ONE, 32'h04, 0);
    outs(1, `ADDR_CTRL_TWO, 32'h42, 200 * 5 / 50);
    outs(1, `ADDR_CTRL_TWO, 32'h40, 0);
    wr(`ADDR_CTRL_ONE, 32'h05);
    wr(`ADDR_CTRL_TWO, 32'h43);
    run_chk(1'b1, 1'b0, 3'h6);
    run_chk(1'b0, 1'b0, 3'h7);
    wr(`ADDR_CTRL_ONE, 32'h04);
    wr(`ADDR_CTRL_TWO, 32'h40);
    run_chk(1'b1, 1'b0, 3'h0);
    run_chk(1'b0, 1'b0, 3'h5);
    wr(`ADDR_CTRL_ONE, 32'h44);
    src(2'h1);
    wr(`ADDR_CTRL_TWO, 32'h48);
    run_chk(1'b0, 1'b0, 3'h4);
    run_chk(1'b0, 1'b1, 3'h5);
    wr(`ADDR_CTRL_TWO, 32'h40);
    run_chk(1'b0, 1'b0, 3'h5);
    $display("test outputs, stop and low power done");
    print_verdict();
  end
endmodule : tb_fll_clock_regs
`default_nettype wire
